// ==== src/writer_pkg.sv ====
// Package: constants and types for the flash writer-mode command port
package writer_pkg;

  // ----------------------------------------------------------------
  // Command bytes and field layout
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_READ      = 8'h00;
  localparam logic [7:0] CMD_PROGRAM   = 8'h40;
  localparam logic [7:0] CMD_ERASE     = 8'h20;
  localparam logic [7:0] CMD_STATUS    = 8'h71;
  localparam logic [7:0] ERASED_BYTE   = 8'hFF;
  localparam logic [6:0] PAGE_LOW_ZERO = 7'h00;
  localparam logic [6:0] PAGE_LAST     = 7'h7F;
  localparam int         ADDR_W        = 18;
  localparam int         ARRAY_W       = 16;
  localparam int         ARRAY_BYTES   = 65536;
  localparam int         PAGE_BYTES    = 128;

  // Return code bit positions
  localparam int BIT_ABNORMAL  = 7;
  localparam int BIT_CMD_ERR   = 6;
  localparam int BIT_PROG_ERR  = 5;
  localparam int BIT_ERASE_ERR = 4;
  localparam int BIT_COUNT_ERR = 1;
  localparam int BIT_ADDR_ERR  = 0;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Timing: internal busy time of each operation
  // ----------------------------------------------------------------
  localparam int CLK_NS         = 100;
  localparam int WRITE_TIME_US  = 1000;
  localparam int ERASE_TIME_US  = 100000;
  localparam int WRITE_CYCLES   = (WRITE_TIME_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int ERASE_CYCLES   = (ERASE_TIME_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int BUSY_W         = 24;

  typedef enum logic [2:0]
  {
    ST_WAIT     = 3'b000,
    ST_READ     = 3'b001,
    ST_LOAD     = 3'b010,
    ST_BUSY     = 3'b011,
    ST_ERASE2   = 3'b100,
    ST_STATUS2  = 3'b101,
    ST_STATUS   = 3'b110,
    ST_DONE     = 3'b111
  } state_t;

  // Parallel strobe group from the programmer
  typedef struct packed
  {
    logic chip_enable_n;
    logic output_enable_n;
    logic write_enable_n;
  } strobes_t;

endpackage : writer_pkg

// ==== src/flash_writer_mode_command_port.sv ====
// Design: writer-mode command port with on-chip flash array
// Operation
// - Supports read, auto-program, auto-erase and status read modes.
// - CE low, OE high, WE low: command write taken, address in program.
// - CE high floats data pins; logic keeps operating, no standby.
// - Command 00 enters memory read; following reads return addressed data.
// - Command 40 then 128 data writes, each with its address.
// - Memory read returns one byte per access.
// - Program writes a 128-byte page at once; end seen by polling.
// - Bit 6 shows completion, bit 7 an error; status read shows error details.
// - After program, erase or status, return to command wait.
// - Memory read mode accepts commands like command wait.
// - Any number of reads follow one read command.
// - After reset the device is in memory read mode.
// - Polling bits 6 and 7 held until next command write.
// - Return code: bit7 abnormal, 6 command, 5 program, 4 erase, 1 count, 0 address.
module flash_writer_mode_command_port
  import writer_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      reset_n,
  input  wire writer_pkg::strobes_t      strobes,
  input  wire logic [writer_pkg::ADDR_W-1:0] flash_address_pins,
  input  wire logic [7:0]                flash_data_pins_in,
  output logic      [7:0]                flash_data_pins_out,
  output logic                           flash_data_pins_oe,
  output logic                           busy
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0]          array_mem [ARRAY_BYTES];
  logic [7:0]          page_buf  [PAGE_BYTES];
  // Sequencer state, return code and polling byte
  state_t              state;
  state_t              next_state;
  logic [7:0]          return_code;
  logic [7:0]          next_return_code;
  logic [7:0]          poll_byte;
  logic [7:0]          next_poll_byte;
  // Page counter, busy timer and operation kind
  logic [7:0]          byte_count;
  logic [7:0]          next_byte_count;
  logic [ARRAY_W-1:0]  page_base;
  logic [ARRAY_W-1:0]  next_page_base;
  logic [BUSY_W-1:0]   busy_count;
  logic [BUSY_W-1:0]   next_busy_count;
  logic                erasing;
  logic                next_erasing;
  // Strobe decode, read path and commit strobes
  logic                write_prev;
  logic [7:0]          read_data;
  logic [7:0]          next_flash_data_pins_out;
  logic                next_flash_data_pins_oe;
  logic                write_strobe;
  logic                read_cycle;
  logic                commit_page;
  logic                commit_erase;
  // Erase walk pointer; top bit set means idle
  logic [16:0]         erase_index;
  logic [16:0]         next_erase_index;

  // Decoded strobe combinations
  function automatic logic is_read(input strobes_t s);
    return !s.chip_enable_n && !s.output_enable_n && s.write_enable_n;
  endfunction : is_read

  function automatic logic is_write(input strobes_t s);
    return !s.chip_enable_n && s.output_enable_n && !s.write_enable_n;
  endfunction : is_write

  // ----------------------------------------------------------------
  // Strobe edge detection
  // ----------------------------------------------------------------
  // Command taken once per write condition, on its leading clock
  // Tracking the whole condition, not WE alone, lets a WE pulse with CE high
  // leave no trace, and a write led by CE is still taken
  assign write_strobe = is_write(strobes) && !write_prev;
  assign read_cycle   = is_read(strobes);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      write_prev <= 1'b0;
    else
      write_prev <= is_write(strobes);
  end

  // ----------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------
  // Commands during busy are dropped; the programmer must not send them
  always_comb
  begin
    next_state       = state;
    next_return_code = return_code;
    next_poll_byte   = poll_byte;
    next_byte_count  = byte_count;
    next_page_base   = page_base;
    next_busy_count  = busy_count;
    next_erasing     = erasing;
    commit_page      = 1'b0;
    commit_erase     = 1'b0;
    unique case (state)
      // Idle states all take new commands alike
      ST_WAIT, ST_READ, ST_STATUS, ST_DONE:
      begin
        if (write_strobe)
        begin
          next_poll_byte = 8'h00;
          unique case (flash_data_pins_in)
            CMD_READ:    next_state = ST_READ;
            CMD_PROGRAM:
            begin
              next_state      = ST_LOAD;
              next_byte_count = 8'h00;
            end
            CMD_ERASE:   next_state = ST_ERASE2;
            CMD_STATUS:  next_state = ST_STATUS2;
            default:
            begin
              next_state                    = ST_WAIT;
              next_return_code[BIT_CMD_ERR]  = 1'b1;
              next_return_code[BIT_ABNORMAL] = 1'b1;
            end
          endcase
        end
      end
      // Data writes fill the page buffer in arrival order
      ST_LOAD:
      begin
        if (write_strobe)
        begin
          // Page address taken from the first data cycle
          if (byte_count == 8'h00)
          begin
            next_page_base = {flash_address_pins[ARRAY_W-1:7], PAGE_LOW_ZERO};
            if (flash_address_pins[6:0] != PAGE_LOW_ZERO)
            begin
              next_return_code[BIT_ADDR_ERR]  = 1'b1;
              next_return_code[BIT_ABNORMAL] = 1'b1;
            end
          end
          next_byte_count = byte_count + 8'h01;
          if (byte_count[6:0] == PAGE_LAST)
          begin
            next_state      = ST_BUSY;
            next_erasing    = 1'b0;
            next_busy_count = BUSY_W'(WRITE_CYCLES);
          end
        end
      end
      // Second erase byte must repeat the erase command
      ST_ERASE2:
      begin
        if (write_strobe)
        begin
          if (flash_data_pins_in == CMD_ERASE)
          begin
            next_state      = ST_BUSY;
            next_erasing    = 1'b1;
            next_busy_count = BUSY_W'(ERASE_CYCLES);
          end
          else
          begin
            next_state                    = ST_WAIT;
            next_return_code[BIT_CMD_ERR]  = 1'b1;
            next_return_code[BIT_ABNORMAL] = 1'b1;
          end
        end
      end
      // Second status byte must repeat the status command
      ST_STATUS2:
      begin
        if (write_strobe)
        begin
          if (flash_data_pins_in == CMD_STATUS)
            next_state = ST_STATUS;
          else
          begin
            next_state                    = ST_WAIT;
            next_return_code[BIT_CMD_ERR]  = 1'b1;
            next_return_code[BIT_ABNORMAL] = 1'b1;
          end
        end
      end
      // Timer counts down; page or erase is committed on its last cycle
      ST_BUSY:
      begin
        next_busy_count = busy_count - BUSY_W'(1);
        if (busy_count == BUSY_W'(1))
        begin
          commit_page  = !erasing;
          commit_erase = erasing;
          next_state   = ST_DONE;
          // Completion bit set, bit 7 reports any error so far
          next_poll_byte = {next_return_code[BIT_ABNORMAL], 1'b1, 6'h00};
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state       <= ST_READ;
      return_code <= STATUS_RESET;
      poll_byte   <= 8'h00;
      byte_count  <= 8'h00;
      page_base   <= '0;
      busy_count  <= '0;
      erasing     <= 1'b0;
    end
    else
    begin
      state       <= next_state;
      return_code <= next_return_code;
      poll_byte   <= next_poll_byte;
      byte_count  <= next_byte_count;
      page_base   <= next_page_base;
      busy_count  <= next_busy_count;
      erasing     <= next_erasing;
    end
  end

  // ----------------------------------------------------------------
  // Array and page buffer
  // ----------------------------------------------------------------
  // Erase walks one byte per clock after the timer; far below erase time
  assign next_erase_index = commit_erase ? 17'h00000 :
                            (erase_index[16] ? erase_index : erase_index + 17'h00001);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      erase_index <= 17'h10000;
    else
      erase_index <= next_erase_index;
  end

  // Memories carry no reset; contents survive reset like flash cells
  always_ff @(posedge clk)
  begin
    if (state == ST_LOAD && write_strobe)
      page_buf[byte_count[6:0]] <= flash_data_pins_in;
    if (!erase_index[16])
      array_mem[erase_index[ARRAY_W-1:0]] <= ERASED_BYTE;
    if (commit_page)
    begin
      for (int i = 0; i < PAGE_BYTES; i++)
        array_mem[page_base + ARRAY_W'(i)] <= page_buf[i];
    end
    read_data <= array_mem[flash_address_pins[ARRAY_W-1:0]];
  end

  // ----------------------------------------------------------------
  // Data pin drive
  // ----------------------------------------------------------------
  // Output source chosen by mode; pins float unless a read is strobed
  always_comb
  begin
    next_flash_data_pins_oe = read_cycle;
    if (state == ST_READ)
      next_flash_data_pins_out = read_data;
    else if (state == ST_STATUS)
      next_flash_data_pins_out = return_code;
    else
      next_flash_data_pins_out = poll_byte;
  end

  // Registered drive keeps the pins free of decode glitches
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      flash_data_pins_out <= 8'h00;
      flash_data_pins_oe  <= 1'b0;
    end
    else
    begin
      flash_data_pins_out <= next_flash_data_pins_out;
      flash_data_pins_oe  <= next_flash_data_pins_oe;
    end
  end

  // ----------------------------------------------------------------
  // Busy indication
  // ----------------------------------------------------------------
  // Straight from the state register, so it never lags the timer
  assign busy = (state == ST_BUSY);

endmodule : flash_writer_mode_command_port

// ==== verification/writer_port_checker.sv ====
// Checker: concurrent assertions on the writer-mode command port
module writer_port_checker
  import writer_pkg::*;
(
  input wire logic                      clk,
  input wire logic                      reset_n,
  input wire writer_pkg::strobes_t      strobes,
  input wire logic [writer_pkg::ADDR_W-1:0] flash_address_pins,
  input wire logic [7:0]                flash_data_pins_in,
  input wire logic [7:0]                flash_data_pins_out,
  input wire logic                      flash_data_pins_oe,
  input wire logic                      busy
);
  int   busy_len;
  logic poll_mode;
  logic rd;
  assign rd = !strobes.chip_enable_n && !strobes.output_enable_n && strobes.write_enable_n;
  // ----------------------------------------------------------------
  // Busy run length; too long for a repetition, so a counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      busy_len  <= 0;
      poll_mode <= 1'b0;
    end
    else
    begin
      busy_len  <= busy ? busy_len + 1 : 0;
      poll_mode <= $fell(busy) | (poll_mode & strobes.write_enable_n); // Ends at next write
    end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  AST_CHIP_OFF : assert property (strobes.chip_enable_n |=> !flash_data_pins_oe)
    else $error("pins driven while chip disabled");
  AST_OUT_OFF : assert property (!strobes.chip_enable_n && strobes.output_enable_n |=> !flash_data_pins_oe)
    else $error("pins driven without output enable");
  AST_READ_ON : assert property (rd && !busy |=> flash_data_pins_oe)
    else $error("read strobes did not drive pins");
  AST_BUSY_LEN : assert property ($fell(busy) |-> busy_len == WRITE_CYCLES || busy_len == ERASE_CYCLES)
    else $error("program busy time wrong");
  AST_POLL_BIT : assert property (rd[*4] ##0 poll_mode |-> flash_data_pins_out[6])
    else $error("completion bit not shown");
  AST_BUSY_CAUSE : assert property ($rose(busy) |-> $past(strobes == 3'b010))
    else $error("busy without command write");
  AST_READ_STABLE : assert property ((rd && !busy && $stable(flash_address_pins))[*3] |-> $stable(flash_data_pins_out))
    else $error("read data moved");
  AST_CHIP_IGNORE : assert property (strobes.chip_enable_n && !busy |=> !busy)
    else $error("strobes taken while chip disabled");
endmodule : writer_port_checker

bind flash_writer_mode_command_port writer_port_checker checker_inst (.clk(clk), .reset_n(reset_n),
  .strobes(strobes), .flash_address_pins(flash_address_pins), .flash_data_pins_in(flash_data_pins_in),
  .flash_data_pins_out(flash_data_pins_out), .flash_data_pins_oe(flash_data_pins_oe), .busy(busy));

// ==== verification/programmer_model.sv ====
// Partner: parallel programmer driving the flash pins
module programmer_model
  import writer_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      busy,
  input  wire logic [7:0]                flash_data_pins_out,
  input  wire logic                      flash_data_pins_oe,
  output writer_pkg::strobes_t           strobes,
  output logic [writer_pkg::ADDR_W-1:0]  flash_address_pins,
  output logic [7:0]                     flash_data_pins_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // Straps held for the whole run
  logic mode_select_high = 1'b0;
  logic mode_select_low  = 1'b0;
  logic standby_n        = 1'b1;
  initial
  begin
    strobes            = 3'b111;
    flash_address_pins = '0;
    flash_data_pins_in = 8'h5A;
  end
  // ----------------------------------------------------------------
  // Pin cycles; all changes on the falling edge
  // ----------------------------------------------------------------
  task automatic hold(input logic [2:0] s, input int n);
    @(negedge clk);
    strobes = s;
    repeat (n) @(negedge clk);
  endtask : hold
  task automatic cmd_write(input logic [17:0] a, input logic [7:0] d);
    @(negedge clk);
    strobes            = 3'b010;
    flash_address_pins = a;
    flash_data_pins_in = d;
    @(negedge clk);
    strobes            = 3'b011;
    flash_data_pins_in = ~d; // Released bus shows no stale value
  endtask : cmd_write
  task automatic read_byte(input logic [17:0] a, output logic [7:0] d, output logic oe);
    @(negedge clk);
    strobes            = 3'b001;
    flash_address_pins = a;
    repeat (4) @(negedge clk);
    d       = flash_data_pins_out;
    oe      = flash_data_pins_oe;
    strobes = 3'b011;
  endtask : read_byte
  task automatic program_page(input logic [17:0] a, input logic [7:0] b [PAGE_BYTES]);
    cmd_write(a, CMD_PROGRAM);
    for (int i = 0; i < PAGE_BYTES; i++)
      cmd_write(a + 18'(i), b[i]);
  endtask : program_page
  // Waits for busy to end, giving up after two program times
  task automatic wait_idle(output logic ok);
    int n;
    n = 0;
    while (busy === 1'b1 && n < 2 * WRITE_CYCLES)
    begin
      @(negedge clk);
      n++;
    end
    ok = !busy;
  endtask : wait_idle
endmodule : programmer_model

// ==== verification/flash_writer_mode_command_port_bench.sv ====
// Bench: self-checking run of the writer-mode command port
module flash_writer_mode_command_port_bench
  import writer_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk;
  logic reset_n;
  strobes_t strobes;
  logic [ADDR_W-1:0] addr;
  logic [7:0] din;
  logic [7:0] dout;
  logic oe;
  logic busy;
  int fails;
  int total_checks;
  flash_writer_mode_command_port uut (.clk(clk), .reset_n(reset_n), .strobes(strobes),
    .flash_address_pins(addr), .flash_data_pins_in(din), .flash_data_pins_out(dout),
    .flash_data_pins_oe(oe), .busy(busy));
  programmer_model prog (.clk(clk), .busy(busy), .flash_data_pins_out(dout), .flash_data_pins_oe(oe),
    .strobes(strobes), .flash_address_pins(addr), .flash_data_pins_in(din));
  // ----------------------------------------------------------------
  // Clock, checks and verdict
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    total_checks++;
    if (seen !== want)
    begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  function automatic logic [7:0] ret_code(input logic ce, input logic ae);
    return {ce | ae, ce, 5'h00, ae};
  endfunction : ret_code
  task automatic do_reset;
    reset_n = 1'b0;
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
  endtask : do_reset
  // Hang guard, well past two program times
  initial
  begin
    repeat (40000) @(posedge clk);
    fails++;
    print_verdict();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [7:0]  d;
    logic        o;
    logic        ok;
    logic [17:0] base;
    logic [7:0]  page [PAGE_BYTES];
    reset_n      = 1'b0;
    fails        = 0;
    total_checks = 0;
    void'($urandom(26));
    do_reset();
    prog.read_byte(18'h0, d, o);
    check(8'(o), 8'h01);
    prog.hold(3'b011, 2);
    check(8'(oe), 8'h00);
    prog.hold(3'b100, 2);
    check({7'h00, oe | busy}, 8'h00);
    base = {2'b00, 9'($urandom), 7'h00};
    for (int i = 0; i < PAGE_BYTES; i++)
      page[i] = 8'($urandom);
    page[PAGE_BYTES-1] = ERASED_BYTE;
    prog.program_page(base, page);
    check(8'(busy), 8'h01);
    prog.wait_idle(ok);
    check(8'(ok), 8'h01);
    prog.read_byte(base ^ 18'h55, d, o);
    check(d & 8'hC0, 8'h40);
    prog.read_byte(base, d, o);
    check(d & 8'hC0, 8'h40);
    prog.cmd_write(18'h0, CMD_READ);
    for (int i = 0; i < PAGE_BYTES; i++)
    begin
      prog.read_byte(base + 18'(i), d, o);
      check(d, page[i]);
    end
    prog.cmd_write(18'h3, CMD_STATUS);
    prog.cmd_write(18'h9, CMD_STATUS);
    prog.read_byte(18'h0, d, o);
    check(d, ret_code(1'b0, 1'b0));
    d = 8'($urandom) | 8'h82; // Never one of the four commands
    prog.cmd_write(18'h0, d);
    prog.cmd_write(18'h0, CMD_STATUS);
    prog.cmd_write(18'h0, CMD_STATUS);
    prog.read_byte(18'h0, d, o);
    check(d, ret_code(1'b1, 1'b0));
    prog.program_page(base + 18'h105, page);
    prog.wait_idle(ok);
    prog.read_byte(18'h0, d, o);
    check(d & 8'hC0, 8'hC0);
    prog.cmd_write(18'h0, CMD_STATUS);
    prog.cmd_write(18'h0, CMD_STATUS);
    prog.read_byte(18'h0, d, o);
    check(d, ret_code(1'b1, 1'b1));
    prog.cmd_write(18'h0, CMD_ERASE);
    prog.cmd_write(18'h0, CMD_ERASE);
    check(8'(busy), 8'h01);
    do_reset();
    prog.read_byte(base, d, o);
    check({6'h00, busy, o}, 8'h01);
    check(d, page[0]);
    print_verdict();
  end
endmodule : flash_writer_mode_command_port_bench
